// [core/cses_sequencer.v]
// processing-state and exception sequencer with apb register access
`timescale 1ns/1ps
// How it works
// - reset beats interrupt, interrupt beats trap when causes coincide.
// - reset pin low aborts everything, enters reset state, masks interrupts.
// - reset pin release starts reset handling: fetch start vector, run.
// - reset sets the interrupt mask flag to one.
// - no interrupt taken during reset handling or at its end.
// - interrupts taken only at instruction end, exception sequence end, or in sleep or software standby.
// - no interrupt sampling after flag-modifying instructions.
// - software trap starts trap handling, ignoring masks, unless an interrupt is taken at the same instruction end.
// - program counter and flags pushed via stack pointer before flag update.
// - user bit enable one sets mask only; zero sets mask and second flag.
// - after flag update fetch vector and branch there.
// - external bus request releases bus; cpu halts until returned.
// - no interrupt accepted while bus released.
// - watchdog overflow enters reset state like the reset pin.
// - halt with standby select zero enters sleep, registers kept.
// - halt with standby select one enters software standby, modules reset.
// - hardware standby pin low halts clocks, resets modules.
// - a state is one clock; bus cycles last two or three states.
// - on-chip memory: two states, 16-bit path.
// - peripheral registers: three states, 8 or 16 bit by register.
// - eight external areas, each with own width and length.
// - standby select is system control bit 7, resets to zero.
// - user bit enable resets to one.
module cses_sequencer #(
	parameter [23:0] RAM_BASE = 24'hFFEF10,
	parameter [23:0] IO_BASE  = 24'hFEE000,
	parameter [23:0] IO_END   = 24'hFEE0FF
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        reset_in_low,
	input  wire        hw_standby_in,
	input  wire        bus_req_in,
	input  wire        wdt_overflow,
	input  wire        irq_req,
	input  wire        irq_nmi,
	input  wire        irq_ui_level,
	input  wire [23:0] irq_vec_addr,
	input  wire        instr_done,
	input  wire [2:0]  instr_kind,
	input  wire [1:0]  trap_num,
	input  wire [23:0] pc_next_in,
	input  wire        io_wide_in,
	input  wire [15:0] mem_rdata,
	output reg         mem_valid,
	output reg  [23:0] mem_addr,
	output reg         mem_we,
	output reg  [15:0] mem_wdata,
	output reg         mem_wide,
	output wire        mem_last,
	output wire        cpu_run,
	output reg         branch_valid,
	output reg  [23:0] branch_addr,
	output wire        bus_grant,
	output wire        periph_rst,
	output wire        clk_halt
);
`include "cses_consts.vh"

// processing states; the status register shows these codes
localparam [3:0] S_RST   = 4'h0;
localparam [3:0] S_RV1   = 4'h1;
localparam [3:0] S_RV2   = 4'h2;
localparam [3:0] S_EXEC  = 4'h3;
localparam [3:0] S_PSH1  = 4'h4;
localparam [3:0] S_PSH2  = 4'h5;
localparam [3:0] S_FLAG  = 4'h6;
localparam [3:0] S_VEC1  = 4'h7;
localparam [3:0] S_VEC2  = 4'h8;
localparam [3:0] S_SLEEP = 4'h9;
localparam [3:0] S_SSTBY = 4'hA;
localparam [3:0] S_HSTBY = 4'hB;
localparam [3:0] S_BUSRL = 4'hC;

// architectural registers and bus cycle bookkeeping
reg [3:0]  state;
reg [3:0]  next_state;
reg [7:0]  system_control_reg;
reg [7:0]  cond_code_reg;
reg [23:0] sp;
reg [15:0] area_cfg;
reg [23:0] pc_ret;
reg [23:0] vec_addr;
reg [7:0]  vec_hi;
reg        mem_busy;
reg [1:0]  mem_cnt;
reg [1:0]  mem_len;
reg        rst_s1;
reg        rst_s2;
reg        stb_s1;
reg        stb_s2;
reg        brq_s1;
reg        brq_s2;
reg        rst_quiet;
reg [31:0] rd_mux;

//////////////////////////////////////////////////////////////////////
// pin synchronisers: first stage feeds only the second
// standby stages start high, its idle level, so no false entry
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		rst_s1 <= 1'b0;
		rst_s2 <= 1'b0;
		stb_s1 <= 1'b1;
		stb_s2 <= 1'b1;
		brq_s1 <= 1'b0;
		brq_s2 <= 1'b0;
	end else begin
		rst_s1 <= reset_in_low;
		rst_s2 <= rst_s1;
		stb_s1 <= hw_standby_in;
		stb_s2 <= stb_s1;
		brq_s1 <= bus_req_in;
		brq_s2 <= brq_s1;
	end
end

//////////////////////////////////////////////////////////////////////
// access length and width per address class
function [2:0] acc_cfg;
	input [23:0] a;
	input [15:0] cfg;
	input        iow;
	begin
		if (a >= RAM_BASE)
			acc_cfg = {1'b1, `CSES_ONCHIP_ST};
		else if (a >= IO_BASE && a <= IO_END)
			acc_cfg = {iow, `CSES_IO_ST};
		else
			acc_cfg = {cfg[a[23:21]],
				cfg[a[23:21] + 4'h8] ? `CSES_IO_ST : `CSES_SHORT_ST};
	end
endfunction

// interrupt acceptance: nmi ignores masks, ui masks only when ue is 0
wire ui_masks = !system_control_reg[`CSES_UE_BIT] && cond_code_reg[`CSES_UI_BIT] && irq_ui_level;
// the shield after reset handling holds off even the non-maskable source
wire irq_ok   = !rst_quiet && irq_req &&
		(irq_nmi || (!cond_code_reg[`CSES_MASK_BIT] && !ui_masks));
wire in_reset = !rst_s2 || wdt_overflow;

// every exception step that moves data shares one bus engine
wire mem_state = (state == S_RV1) || (state == S_RV2) || (state == S_PSH1) ||
		(state == S_PSH2) || (state == S_VEC1) || (state == S_VEC2);
wire mem_start = mem_state && !mem_busy;
wire mem_done  = mem_busy && (mem_cnt == mem_len - 2'h1);
assign mem_last = mem_done;

// address and data of the cycle the current state needs
reg [23:0] req_addr;
reg        req_we;
reg [15:0] req_data;
always @* begin
	req_we   = 1'b0;
	req_data = 16'h0000;
	case (state)
		S_RV1:   req_addr = `CSES_RESET_VEC;
		S_RV2:   req_addr = `CSES_RESET_VEC + 24'h000002;
		S_PSH1: begin
			req_addr = sp - 24'h000004;
			req_we   = 1'b1;
			req_data = {cond_code_reg, pc_ret[23:16]};
		end
		S_PSH2: begin
			req_addr = sp + 24'h000002;
			req_we   = 1'b1;
			req_data = pc_ret[15:0];
		end
		S_VEC1:  req_addr = vec_addr;
		S_VEC2:  req_addr = vec_addr + 24'h000002;
		default: req_addr = 24'h000000;
	endcase
end

//////////////////////////////////////////////////////////////////////
// bus cycle engine: counts states until the cycle's length is met
// width and length are latched at the start; the class is not re-read
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		mem_busy  <= 1'b0;
		mem_cnt   <= 2'h0;
		mem_len   <= 2'h2;
		mem_valid <= 1'b0;
		mem_addr  <= 24'h000000;
		mem_we    <= 1'b0;
		mem_wdata <= 16'h0000;
		mem_wide  <= 1'b1;
	end else if (in_reset || !stb_s2) begin
		// an abort drops the cycle half done; address, data, width and length stay latched
		mem_busy  <= 1'b0;
		mem_valid <= 1'b0;
		mem_cnt   <= 2'h0;
	end else if (mem_start) begin
		mem_busy  <= 1'b1;
		mem_valid <= 1'b1;
		mem_cnt   <= 2'h0;
		mem_addr  <= req_addr;
		mem_we    <= req_we;
		mem_wdata <= req_data;
		{mem_wide, mem_len} <= acc_cfg(req_addr, area_cfg, io_wide_in);
	end else if (mem_done) begin
		mem_busy  <= 1'b0;
		mem_valid <= 1'b0;
	end else if (mem_busy) begin
		mem_cnt <= mem_cnt + 2'h1;
	end
end

//////////////////////////////////////////////////////////////////////
// processing-state machine
always @* begin
	next_state = state;
	case (state)
		S_RST:   if (!in_reset) next_state = S_RV1;
		S_RV1:   if (mem_done) next_state = S_RV2;
		// reset handling ends straight into execution, no irq check
		S_RV2:   if (mem_done) next_state = S_EXEC;
		S_EXEC: begin
			if (instr_done) begin
				if (instr_kind != `CSES_K_FLAGS && irq_ok)
					next_state = S_PSH1;
				else if (instr_kind == `CSES_K_TRAP)
					next_state = S_PSH1;
				else if (instr_kind == `CSES_K_HALT)
					next_state = system_control_reg[`CSES_STANDBY_SELECT_BIT_BIT] ? S_SSTBY : S_SLEEP;
			end else if (brq_s2) begin
				next_state = S_BUSRL;
			end
		end
		S_PSH1:  if (mem_done) next_state = S_PSH2;
		S_PSH2:  if (mem_done) next_state = S_FLAG;
		S_FLAG:  next_state = S_VEC1;
		S_VEC1:  if (mem_done) next_state = S_VEC2;
		S_VEC2:  if (mem_done) next_state = irq_ok ? S_PSH1 : S_EXEC;
		S_SLEEP: if (irq_ok) next_state = S_PSH1;
		S_SSTBY: if (irq_ok) next_state = S_PSH1;
		S_HSTBY: next_state = S_RST;
		// no interrupt check here: only the return, a reset or hardware standby ends it
		S_BUSRL: if (!brq_s2) next_state = S_EXEC;
		default: next_state = S_RST;
	endcase
	if (in_reset)
		next_state = S_RST;
	if (!stb_s2)
		next_state = S_HSTBY;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		state <= S_RST;
	else
		state <= next_state;
end

// one boundary after reset handling is shielded from every request
always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		rst_quiet <= 1'b1;
	else if (state == S_RST)
		rst_quiet <= 1'b1;
	else if (state == S_EXEC && instr_done)
		rst_quiet <= 1'b0;
end

//////////////////////////////////////////////////////////////////////
// return address, vector and branch
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pc_ret       <= 24'h000000;
		vec_addr     <= 24'h000000;
		vec_hi       <= 8'h00;
		branch_valid <= 1'b0;
		branch_addr  <= 24'h000000;
	end else begin
		branch_valid <= 1'b0;
		// return point is the instruction after the one just finished
		if (state == S_EXEC && instr_done)
			pc_ret <= pc_next_in;
		// a chained interrupt returns to the handler just reached
		if (state == S_VEC2 && mem_done)
			pc_ret <= {vec_hi, mem_rdata};
		if (next_state == S_PSH1 && state != S_PSH1) begin
			if (state == S_EXEC && instr_kind == `CSES_K_TRAP &&
					!(irq_ok && instr_kind != `CSES_K_FLAGS))
				vec_addr <= `CSES_TRAP_BASE + {20'h00000, trap_num, 2'h0};
			else
				vec_addr <= irq_vec_addr;
		end
		// upper byte of the vector longword is ignored
		if ((state == S_RV1 || state == S_VEC1) && mem_done)
			vec_hi <= mem_rdata[7:0];
		if ((state == S_RV2 || state == S_VEC2) && mem_done &&
				next_state == S_EXEC) begin
			branch_valid <= 1'b1;
			branch_addr  <= {vec_hi, mem_rdata};
		end
	end
end

//////////////////////////////////////////////////////////////////////
// apb slave: zero wait states, error on unmapped offsets
// read-only offsets take a write silently; only unmapped ones err
wire apb_wr = psel && penable && pwrite;
wire mapped = (paddr == `CSES_SYSTEM_CONTROL_REG_OFF) || (paddr == `CSES_CCR_OFF) ||
		(paddr == `CSES_SP_OFF) || (paddr == `CSES_STAT_OFF) ||
		(paddr == `CSES_AREA_OFF) || (paddr == `CSES_PC_OFF);
assign pready  = 1'b1;
assign pslverr = psel && penable && !mapped;

always @* begin
	case (paddr)
		`CSES_SYSTEM_CONTROL_REG_OFF: rd_mux = {24'h000000, system_control_reg};
		`CSES_CCR_OFF:   rd_mux = {24'h000000, cond_code_reg};
		`CSES_SP_OFF:    rd_mux = {8'h00, sp};
		`CSES_STAT_OFF:  rd_mux = {27'h0000000, mem_busy, state};
		`CSES_AREA_OFF:  rd_mux = {16'h0000, area_cfg};
		`CSES_PC_OFF:    rd_mux = {8'h00, pc_ret};
		default:         rd_mux = 32'h00000000;
	endcase
end

// read data latched in the setup phase, so the access phase sees a flop
always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		prdata <= 32'h00000000;
	else if (psel && !penable)
		prdata <= rd_mux;
end

// software registers; hardware updates win over a same-cycle write
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		system_control_reg    <= `CSES_SYSTEM_CONTROL_REG_RST;
		cond_code_reg      <= `CSES_CCR_RST;
		sp       <= 24'h000000;
		area_cfg <= 16'hFFFF;
	end else begin
		if (apb_wr && paddr == `CSES_SYSTEM_CONTROL_REG_OFF)
			system_control_reg <= pwdata[7:0];
		if (apb_wr && paddr == `CSES_AREA_OFF)
			area_cfg <= pwdata[15:0];
		if (state == S_PSH1 && mem_done)
			sp <= sp - 24'h000004;
		else if (apb_wr && paddr == `CSES_SP_OFF)
			sp <= pwdata[23:0];
		if (state == S_RST)
			cond_code_reg[`CSES_MASK_BIT] <= 1'b1;
		else if (state == S_FLAG) begin
			cond_code_reg[`CSES_MASK_BIT] <= 1'b1;
			if (!system_control_reg[`CSES_UE_BIT])
				cond_code_reg[`CSES_UI_BIT] <= 1'b1;
		end else if (apb_wr && paddr == `CSES_CCR_OFF)
			cond_code_reg <= pwdata[7:0];
	end
end

//////////////////////////////////////////////////////////////////////
// status toward the rest of the chip
// levels decoded from the state, so they move on the same edge
assign cpu_run    = (state == S_EXEC);
assign bus_grant  = (state == S_BUSRL);
assign periph_rst = (state == S_SSTBY) || (state == S_HSTBY);
assign clk_halt   = (state == S_SSTBY) || (state == S_HSTBY);

endmodule // cses_sequencer

// [core/cses_consts.vh]
// register map, field positions, reset values and timing for the state sequencer
`ifndef CSES_CONSTS_VH
`define CSES_CONSTS_VH

// register byte offsets on the apb bus
`define CSES_SYSTEM_CONTROL_REG_OFF  8'h00
`define CSES_CCR_OFF    8'h04
`define CSES_SP_OFF     8'h08
`define CSES_STAT_OFF   8'h0C
`define CSES_AREA_OFF   8'h10
`define CSES_PC_OFF     8'h14

// system control fields
`define CSES_STANDBY_SELECT_BIT_BIT   7
`define CSES_UE_BIT     3
`define CSES_SYSTEM_CONTROL_REG_RST  8'h09

// condition code fields
`define CSES_MASK_BIT   7
`define CSES_UI_BIT     6
`define CSES_CCR_RST    8'h80

// vectors
`define CSES_RESET_VEC  24'h000000
`define CSES_TRAP_BASE  24'h000020

// access lengths in states
`define CSES_ONCHIP_ST  2'h2
`define CSES_IO_ST      2'h3
`define CSES_SHORT_ST   2'h2

// instruction kinds reported at a boundary
`define CSES_K_PLAIN    3'h0
`define CSES_K_FLAGS    3'h1
`define CSES_K_TRAP     3'h2
`define CSES_K_HALT     3'h3

`endif

// [sim/cses_sequencer_properties.sv]
// port-level assertions for the state sequencer
`timescale 1ns/1ps
`include "cses_consts.vh"
module cses_props #(
	parameter [23:0] RAM_BASE = 24'hFFEF10,
	parameter [23:0] IO_BASE  = 24'hFEE000,
	parameter [23:0] IO_END   = 24'hFEE0FF
) (
	input wire        pclk,
	input wire        presetn,
	input wire        hw_standby_in,
	input wire        reset_in_low,
	input wire        wdt_overflow,
	input wire        instr_done,
	input wire [2:0]  instr_kind,
	input wire        mem_valid,
	input wire [23:0] mem_addr,
	input wire        mem_we,
	input wire        mem_wide,
	input wire        mem_last,
	input wire        cpu_run,
	input wire        branch_valid,
	input wire        bus_grant,
	input wire        periph_rst,
	input wire        clk_halt
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// aborts by pin, standby or watchdog cut cycles short, so they gate the length checks
	wire live = hw_standby_in && reset_in_low && !wdt_overflow;
	wire io_hit = mem_addr >= IO_BASE && mem_addr <= IO_END;
	////////////////////
	chk_grant_idle: assert property (bus_grant |-> !mem_valid && !cpu_run)
		else $error("cycle while bus released");
	chk_wdt_reset: assert property (wdt_overflow |=> !cpu_run)
		else $error("watchdog did not reset");
	chk_cycle_len: assert property ($rose(mem_valid) && live |->
		!mem_last ##1 (mem_last or (!mem_last ##1 mem_last))) else $error("bad cycle length");
	chk_ram_two: assert property ($rose(mem_valid) && live && mem_addr >= RAM_BASE |->
		##1 mem_last && mem_wide) else $error("ram cycle not two wide states");
	chk_io_three: assert property ($rose(mem_valid) && live && io_hit |->
		!mem_last ##1 !mem_last ##1 mem_last) else $error("io cycle not three states");
	chk_hstby_halt: assert property (!hw_standby_in [*5] |-> clk_halt && periph_rst)
		else $error("hardware standby not entered");
	chk_pin_reset: assert property (!reset_in_low [*5] |-> !cpu_run && !mem_valid)
		else $error("reset pin ignored");
	chk_branch_after: assert property (branch_valid |-> $past(mem_last))
		else $error("branch without vector read");
	chk_trap_push: assert property (instr_done && cpu_run && live &&
		instr_kind == `CSES_K_TRAP |-> ##2 mem_valid && mem_we) else $error("trap no push");
	cover property (bus_grant);
	cover property (branch_valid);
	cover property (clk_halt);
endmodule // cses_props
bind cses_sequencer cses_props #(.RAM_BASE(RAM_BASE), .IO_BASE(IO_BASE), .IO_END(IO_END))
	u_props (.pclk(pclk), .presetn(presetn), .hw_standby_in(hw_standby_in),
	.reset_in_low(reset_in_low), .wdt_overflow(wdt_overflow), .instr_done(instr_done),
	.instr_kind(instr_kind), .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_we(mem_we),
	.mem_wide(mem_wide), .mem_last(mem_last), .cpu_run(cpu_run), .branch_valid(branch_valid),
	.bus_grant(bus_grant), .periph_rst(periph_rst), .clk_halt(clk_halt));

// [sim/cses_mem_model.sv]
// far-side memory answering the sequencer's bus cycles
`timescale 1ns/1ps
module cses_mem_model (
	input  wire        pclk,
	input  wire        mem_valid,
	input  wire [23:0] mem_addr,
	input  wire        mem_we,
	output wire [15:0] mem_rdata
);
	reg [15:0] held = 16'h0000;
	// read data folds the address with a pattern; idle bus toggles so stale data never passes
	assign mem_rdata = (mem_valid && !mem_we) ? mem_addr[15:0] ^ 16'hA5A5 : ~held;
	always @(posedge pclk) begin
		held <= mem_rdata;
	end
endmodule // cses_mem_model

// [sim/tb.sv]
// self-checking bench for the state sequencer
`timescale 1ns/1ps
`include "cses_consts.vh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
	$display("Error %s expected %h seen %h", n, e, a); end end
module tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
	logic        reset_in_low = 1, hw_standby_in = 1, bus_req_in = 0, wdt_overflow = 0;
	logic        irq_req = 0, irq_nmi = 0, instr_done = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic [23:0] irq_vec_addr = 24'h000040, pc_next_in = 24'h561234;
	logic [2:0]  instr_kind = 3'h0;
	logic [1:0]  trap_num = 2'h0;
	logic [39:0] rows [5];
	wire  [31:0] prdata;
	wire  [23:0] mem_addr, branch_addr;
	wire  [15:0] mem_rdata, mem_wdata;
	wire         pready, pslverr, mem_valid, mem_we, mem_wide, mem_last, cpu_run;
	wire         branch_valid, bus_grant, periph_rst, clk_halt;
	int          err_count = 0, samples_checked = 0, cyc = 0, n;
	////////////////////
	cses_sequencer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .reset_in_low, .hw_standby_in, .bus_req_in, .wdt_overflow, .irq_req,
		.irq_nmi, .irq_ui_level(1'b0), .irq_vec_addr, .instr_done, .instr_kind, .trap_num,
		.pc_next_in, .io_wide_in(1'b1), .mem_rdata, .mem_valid, .mem_addr, .mem_we, .mem_wdata,
		.mem_wide, .mem_last, .cpu_run, .branch_valid, .branch_addr, .bus_grant, .periph_rst,
		.clk_halt);
	cses_mem_model u_mem (.pclk, .mem_valid, .mem_addr, .mem_we, .mem_rdata);
	// clock and hang guard
	always #4 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			results();
		end
	end
	////////////////////
	// one apb transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic instr(input logic [2:0] k);
		@(posedge pclk);
		instr_done <= 1'b1;
		instr_kind <= k;
		@(posedge pclk);
		instr_done <= 1'b0;
	endtask
	task automatic wait_branch(input logic [23:0] e);
		n = 0;
		do begin @(posedge pclk); n++; end while (branch_valid !== 1'b1 && n < 300);
		`CHK("branch_addr", e, branch_addr)
	endtask
	task automatic wait_run();
		n = 0;
		while (cpu_run !== 1'b1 && n < 300) begin @(posedge pclk); n++; end
		`CHK("cpu_run", 1'b1, cpu_run)
	endtask
	// vector words are predicted from the memory model's fold
	function automatic logic [23:0] vec(input logic [15:0] a);
		return {8'(a ^ 16'hA5A5), (a + 16'h2) ^ 16'hA5A5};
	endfunction
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////
	initial begin
		rows = '{{`CSES_SYSTEM_CONTROL_REG_OFF, 24'h0, `CSES_SYSTEM_CONTROL_REG_RST}, {`CSES_CCR_OFF, 24'h0, `CSES_CCR_RST},
			{`CSES_SP_OFF, 32'h0}, {`CSES_AREA_OFF, 32'h0000FFFF}, {`CSES_STAT_OFF, 32'h3}};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		wait_run();
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, rows[i][39:32], 32'h0);
			`CHK("reg", rows[i][31:0], rd)
		end
		apb(1'b0, 8'h40, 32'h0);
		`CHK("pslverr", 1'b1, se)
		$display("reset values done");
		// traps with each user-enable setting, last one stacking into io space
		for (int ue = 0; ue < 3; ue++) begin
			apb(1'b1, `CSES_SYSTEM_CONTROL_REG_OFF, 32'((ue & 1) << 3));
			apb(1'b1, `CSES_CCR_OFF, 32'h0);
			apb(1'b1, `CSES_SP_OFF, ue < 2 ? 32'h00FFFF00 : 32'h00FEE008);
			trap_num <= 2'(ue);
			instr(`CSES_K_TRAP);
			@(posedge pclk iff (mem_valid === 1'b1 && mem_we === 1'b1));
			`CHK("mem_addr", ue < 2 ? 24'hFFFEFC : 24'hFEE004, mem_addr)
			`CHK("mem_wdata", 16'h0056, mem_wdata)
			wait_branch(vec(16'h0020 + 16'(4 * ue)));
			apb(1'b0, `CSES_CCR_OFF, 32'h0);
			`CHK("ccr", (ue & 1) ? 32'h80 : 32'hC0, rd)
			apb(1'b0, `CSES_SP_OFF, 32'h0);
			`CHK("sp", ue < 2 ? 32'h00FFFEFC : 32'h00FEE004, rd)
		end
		$display("trap done");
		apb(1'b1, `CSES_CCR_OFF, 32'h0);
		irq_req <= 1'b1;
		instr(`CSES_K_FLAGS);
		repeat (2) @(posedge pclk);
		`CHK("mem_valid", 1'b0, mem_valid)
		instr(`CSES_K_TRAP);
		wait_branch(vec(16'h0040));
		$display("priority done");
		apb(1'b1, `CSES_CCR_OFF, 32'h0);
		bus_req_in <= 1'b1;
		repeat (6) @(posedge pclk);
		`CHK("bus_grant", 1'b1, bus_grant)
		instr(`CSES_K_PLAIN);
		repeat (2) @(posedge pclk);
		`CHK("mem_valid", 1'b0, mem_valid)
		`CHK("bus_grant", 1'b1, bus_grant)
		bus_req_in <= 1'b0;
		irq_req <= 1'b0;
		wait_run();
		$display("bus release done");
		// halt to sleep then software standby, each woken by nmi
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, `CSES_SYSTEM_CONTROL_REG_OFF, 32'((s << 7) | 8));
			instr(`CSES_K_HALT);
			repeat (3) @(posedge pclk);
			`CHK("cpu_run", 1'b0, cpu_run)
			`CHK("periph_rst", 1'(s), periph_rst)
			`CHK("clk_halt", 1'(s), clk_halt)
			// nmi only lifts the masks of a raised request, so both are driven
			irq_req <= 1'b1;
			irq_nmi <= 1'b1;
			@(posedge pclk iff mem_valid === 1'b1);
			irq_req <= 1'b0;
			irq_nmi <= 1'b0;
			wait_branch(vec(16'h0040));
		end
		$display("halt done");
		apb(1'b1, `CSES_CCR_OFF, 32'h0);
		reset_in_low <= 1'b0;
		irq_req <= 1'b1;
		irq_nmi <= 1'b1;
		repeat (6) @(posedge pclk);
		`CHK("cpu_run", 1'b0, cpu_run)
		reset_in_low <= 1'b1;
		wait_run();
		instr(`CSES_K_PLAIN);
		repeat (2) @(posedge pclk);
		`CHK("mem_valid", 1'b0, mem_valid)
		irq_nmi <= 1'b0;
		irq_req <= 1'b0;
		apb(1'b0, `CSES_CCR_OFF, 32'h0);
		`CHK("ccr", 32'h80, rd)
		$display("reset pin done");
		wdt_overflow <= 1'b1;
		@(posedge pclk);
		wdt_overflow <= 1'b0;
		@(posedge pclk);
		`CHK("cpu_run", 1'b0, cpu_run)
		wait_run();
		hw_standby_in <= 1'b0;
		repeat (6) @(posedge pclk);
		`CHK("clk_halt", 1'b1, clk_halt && periph_rst)
		hw_standby_in <= 1'b1;
		wait_run();
		$display("standby done");
		results();
	end
endmodule // tb
